// file: cswu_pkg.sv
// Constants and types of the clock-switch warm-up counter.
// Assumes nothing of its surroundings; imported by every design file.
package cswu_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;

  // ----------------------------------------------------------------
  // System control two: bit positions and value after reset
  // ----------------------------------------------------------------
  localparam int FAST_OSC_EN_BIT = 7;
  localparam int SLOW_OSC_EN_BIT = 6;
  localparam int CLK_SEL_BIT = 5;
  localparam logic [7:0] SYSCTL_RST = 8'h80;

  // ----------------------------------------------------------------
  // Timer control fields
  // ----------------------------------------------------------------
  localparam int OUT_FLOP_BIT = 7;
  localparam int RUN_BIT = 3;
  localparam int MODE_LSB = 0;
  localparam int SRC_LSB = 4;
  localparam logic [2:0] UPPER_MODE_WARMUP = 3'h5;
  localparam logic [2:0] LOWER_MODE_CASCADE = 3'h3;
  localparam logic [2:0] SRC_CODE_SLOW = 3'h4;
  localparam logic [2:0] SRC_CODE_FAST = 3'h6;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'hffff;

  // ----------------------------------------------------------------
  // Warm-up timing: one compare step is one upper-byte unit.
  // ----------------------------------------------------------------
  localparam int SLOW_CLK_HZ = 32768;
  localparam int FAST_CLK_HZ = 16000000;
  localparam logic [15:0] CMP_MIN = 16'h0100;
  localparam logic [15:0] CMP_MAX = 16'hff00;
  localparam int TICKS_PER_STEP = 2 ** BYTE_W;

  typedef enum logic [1:0] {
    CSWU_SRC_NONE,
    CSWU_SRC_SLOW,
    CSWU_SRC_FAST
  } cswu_src_t;

  function automatic cswu_src_t cswu_src_decode(input logic [7:0] ctl);
    cswu_src_t s;
    s = CSWU_SRC_NONE;
    if (ctl[SRC_LSB +: 3] == SRC_CODE_SLOW) begin
      s = CSWU_SRC_SLOW;
    end else if (ctl[SRC_LSB +: 3] == SRC_CODE_FAST) begin
      s = CSWU_SRC_FAST;
    end
    return s;
  endfunction

endpackage

// file: cswu_cnt_if.sv
// Link between the control logic and the cascaded warm-up counter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface cswu_cnt_if;
  import cswu_pkg::*;
  logic tick;
  logic clear;
  logic [BYTE_W-1:0] cmp_hi;
  logic match;
  logic [CNT_W-1:0] count;
  modport ctl (output tick, output clear, output cmp_hi,
               input match, input count);
  modport counter (input tick, input clear, input cmp_hi,
                   output match, output count);
endinterface
`default_nettype wire

// file: cswu_cascade.sv
// Two byte-wide up-counters chained into one 16-bit warm-up counter.
// Assumes tick is a one-cycle source-clock enable from the control side.
`timescale 1ns/1ps
`default_nettype none
module cswu_cascade
  import cswu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  cswu_cnt_if.counter cnt
);
  localparam int STAGES = CNT_W / BYTE_W;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [STAGES:0] carry;
  logic hit;

  // ----------------------------------------------------------------
  // Carry chain
  // ----------------------------------------------------------------
  assign carry[0] = 1'b1;
  for (genvar g = 0; g < STAGES; g++) begin : g_stage
    assign cnt_d[g*BYTE_W +: BYTE_W] =
      cnt_q[g*BYTE_W +: BYTE_W] + {{(BYTE_W-1){1'b0}}, carry[g]};
    assign carry[g+1] = carry[g] & (&cnt_q[g*BYTE_W +: BYTE_W]);
  end

  // Only the upper byte takes part in the compare.
  assign hit = (cnt_d[CNT_W-1 -: BYTE_W] == cnt.cmp_hi);
  assign cnt.match = cnt.tick & hit;
  assign cnt.count = cnt_q;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (cnt.clear) begin
        cnt_q <= '0;
      end else if (cnt.tick) begin
        cnt_q <= hit ? '0 : cnt_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  carry_into_upper_a: assert property (
    ce_i && cnt.tick && !cnt.clear && !hit && cnt_q[7:0] == 8'hff
    |=> cnt_q[7:0] == 8'h00 && cnt_q[15:8] == $past(cnt_q[15:8]) + 8'h01)
    else $error("Lower byte wrap did not carry into upper byte.");

  count_hold_a: assert property (
    !ce_i || (!cnt.tick && !cnt.clear) |=> $stable(cnt_q))
    else $error("Counter moved without a tick.");

  count_step_a: assert property (
    ce_i && cnt.tick && !cnt.clear && !hit |=> cnt_q == $past(cnt_q) + 16'h1)
    else $error("Counter did not step by one.");
endmodule
`default_nettype wire

// file: cswu_top.sv
// Warm-up counter that times oscillator settling on a clock switch.
// Assumes software writes control values through the strobed ports and
// that the source-clock ticks are one-cycle enables synchronous to mclk_i.
//
// What this block does
// - Counting starts only when run bit set.
// - Match clears counter and raises match request.
// - Slow clock: 0100H gives 7.81 ms, FF00H 1.99 s.
// - Fast clock: 0100H gives 16 us, FF00H 4.08 ms.
// - Lower control 43H: slow source, cascade, flop cleared.
// - Lower control 63H: fast source, cascade, flop cleared.
// - Upper control 05H: warm-up mode, flop cleared, stopped.
// - Control two: fast enable 7, slow 6, select 5.
// - Only compare upper byte matters for matching.
// - Lower timer carries into upper timer.
`timescale 1ns/1ps
`default_nettype none
module cswu_top
  import cswu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic slow_tick_i,
  input wire logic fast_tick_i,
  input wire logic lower_ctl_wr_i,
  input wire logic upper_ctl_wr_i,
  input wire logic [7:0] ctl_wdata_i,
  input wire logic lower_cmp_wr_i,
  input wire logic upper_cmp_wr_i,
  input wire logic [7:0] cmp_wdata_i,
  input wire logic sysctl_wr_i,
  input wire logic [7:0] sysctl_wdata_i,
  input wire logic irq_enable_high_i,
  input wire logic irq_ack_i,
  output logic [cswu_pkg::CNT_W-1:0] count_o,
  output logic upper_timer_run_o,
  output logic lower_output_flop_o,
  output logic upper_output_flop_o,
  output logic [7:0] system_control_two_o,
  output logic fast_osc_en_o,
  output logic slow_osc_en_o,
  output logic sysclk_sel_slow_o,
  output logic upper_timer_match_pending_o,
  output logic upper_timer_match_irq_o
);
  import cswu_pkg::*;

  logic [7:0] lower_timer_control_q;
  logic [7:0] upper_timer_control_q;
  logic [7:0] lower_compare_byte_q;
  logic [7:0] upper_compare_byte_q;
  logic [7:0] system_control_two_q;
  logic pending_q;
  logic pending_d;
  logic irq_q;
  logic warmup;
  logic run;
  logic src_tick;
  cswu_src_t src;

  cswu_cnt_if cnt_if ();

  // ----------------------------------------------------------------
  // Timer control and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lower_timer_control_q <= CTL_RST;
    end else if (ce_i && lower_ctl_wr_i) begin
      lower_timer_control_q <= ctl_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      upper_timer_control_q <= CTL_RST;
    end else if (ce_i && upper_ctl_wr_i) begin
      upper_timer_control_q <= ctl_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lower_compare_byte_q <= CMP_RST[7:0];
      upper_compare_byte_q <= CMP_RST[15:8];
    end else if (ce_i) begin
      if (lower_cmp_wr_i) begin
        lower_compare_byte_q <= cmp_wdata_i;
      end
      if (upper_cmp_wr_i) begin
        upper_compare_byte_q <= cmp_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // System control two
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      system_control_two_q <= SYSCTL_RST;
    end else if (ce_i && sysctl_wr_i) begin
      system_control_two_q <= sysctl_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Source selection and counting enable
  // ----------------------------------------------------------------
  assign src = cswu_src_decode(lower_timer_control_q);
  assign warmup =
    upper_timer_control_q[MODE_LSB +: 3] == UPPER_MODE_WARMUP &&
    lower_timer_control_q[MODE_LSB +: 3] == LOWER_MODE_CASCADE;
  assign run = upper_timer_control_q[RUN_BIT];

  always_comb begin
    src_tick = 1'b0;
    case (src)
      CSWU_SRC_SLOW: src_tick = slow_tick_i;
      CSWU_SRC_FAST: src_tick = fast_tick_i;
      default: src_tick = 1'b0;
    endcase
  end

  assign cnt_if.tick = ce_i & run & warmup & src_tick;
  // Reconfiguring the lower timer restarts the count from zero.
  assign cnt_if.clear = lower_ctl_wr_i;
  assign cnt_if.cmp_hi = upper_compare_byte_q;

  cswu_cascade u_cascade (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .cnt(cnt_if)
  );

  // ----------------------------------------------------------------
  // Match request: a match in the acknowledge cycle wins.
  // ----------------------------------------------------------------
  assign pending_d = cnt_if.match | (pending_q & ~irq_ack_i);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pending_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      pending_q <= pending_d;
      irq_q <= pending_d & irq_enable_high_i;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign count_o = cnt_if.count;
  assign upper_timer_run_o = upper_timer_control_q[RUN_BIT];
  assign lower_output_flop_o = lower_timer_control_q[OUT_FLOP_BIT];
  assign upper_output_flop_o = upper_timer_control_q[OUT_FLOP_BIT];
  assign system_control_two_o = system_control_two_q;
  assign fast_osc_en_o = system_control_two_q[FAST_OSC_EN_BIT];
  assign slow_osc_en_o = system_control_two_q[SLOW_OSC_EN_BIT];
  assign sysclk_sel_slow_o = system_control_two_q[CLK_SEL_BIT];
  assign upper_timer_match_pending_o = pending_q;
  assign upper_timer_match_irq_o = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sequence s_match;
    ce_i && cnt_if.match;
  endsequence

  sequence s_cleared_flagged;
    count_o == 16'h0000 && pending_q;
  endsequence

  stopped_no_count_a: assert property (
    !upper_timer_run_o && !lower_ctl_wr_i |=> $stable(count_o))
    else $error("Counter moved while run bit clear.");

  match_clear_irq_a: assert property (
    s_match |=> s_cleared_flagged)
    else $error("Match did not clear counter and flag request.");

  match_point_a: assert property (
    (s_match and (upper_compare_byte_q != 8'h00))
    |-> count_o == {upper_compare_byte_q - 8'h01, 8'hff})
    else $error("Match fired at wrong count for compare value.");

  min_setting_a: assert property (
    (s_match and (upper_compare_byte_q == CMP_MIN[15:8]))
    |-> count_o == CMP_MIN - 16'h0001)
    else $error("Minimum setting did not give one step of ticks.");

  lower_slow_a: assert property (
    ce_i && lower_ctl_wr_i && ctl_wdata_i == 8'h43
    |=> src == CSWU_SRC_SLOW && !lower_output_flop_o && count_o == 16'h0)
    else $error("Lower control 43 did not select slow cascade.");

  lower_fast_a: assert property (
    ce_i && lower_ctl_wr_i && ctl_wdata_i == 8'h63
    |=> src == CSWU_SRC_FAST && !lower_output_flop_o)
    else $error("Lower control 63 did not select fast cascade.");

  upper_warmup_a: assert property (
    ce_i && upper_ctl_wr_i && ctl_wdata_i == 8'h05
    |=> !upper_timer_run_o && !upper_output_flop_o &&
        upper_timer_control_q[2:0] == UPPER_MODE_WARMUP)
    else $error("Upper control 05 did not give stopped warm-up mode.");

  sysctl_bits_a: assert property (
    ce_i && sysctl_wr_i
    |=> fast_osc_en_o == $past(sysctl_wdata_i[7]) &&
        slow_osc_en_o == $past(sysctl_wdata_i[6]) &&
        sysclk_sel_slow_o == $past(sysctl_wdata_i[5]))
    else $error("Control two bits misplaced.");

  pending_hold_a: assert property (
    ce_i && pending_q && !irq_ack_i |=> pending_q)
    else $error("Match request dropped without acknowledge.");

  irq_gate_a: assert property (
    ce_i |=> upper_timer_match_irq_o ==
      ($past(pending_d) && $past(irq_enable_high_i)))
    else $error("Interrupt output not gated by enable.");
endmodule
`default_nettype wire

// file: cswu_osc_model.sv
// Oscillator model: source-clock ticks for the warm-up counter.
// Assumes one clock; an oscillator that is switched off gives no ticks.
`timescale 1ns/1ps
`default_nettype none
module cswu_osc_model #(
  parameter int SLOW_DIV = 4,
  parameter int FAST_DIV = 2
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic fast_en_i,
  input wire logic slow_en_i,
  output logic slow_tick_o,
  output logic fast_tick_o
);
  int sd_q;
  int fd_q;
  // Ticks only run while the enable is on, so a start made before the
  // oscillator is switched on gives no count.
  always_ff @(posedge mclk_i) begin
    if (srst_i || !slow_en_i) sd_q <= 0;
    else sd_q <= (sd_q == SLOW_DIV - 1) ? 0 : sd_q + 1;
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i || !fast_en_i) fd_q <= 0;
    else fd_q <= (fd_q == FAST_DIV - 1) ? 0 : fd_q + 1;
  end
  assign slow_tick_o = slow_en_i && (sd_q == SLOW_DIV - 1);
  assign fast_tick_o = fast_en_i && (fd_q == FAST_DIV - 1);
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the clock-switch warm-up counter.
// Assumes the design files and the oscillator model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cswu_pkg::*;
  typedef struct {logic [7:0] d; logic [2:0] e;} cswu_row_t;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [5:0] wr = '0;
  logic [7:0] wd = '0;
  logic irq_en = 1'b0;
  logic src_slow = 1'b1;
  logic slow_tick, fast_tick, run, lflop, uflop, fosc, sosc, sel;
  logic pend, irq;
  logic [7:0] sys2;
  logic [CNT_W-1:0] cnt;
  int err_total = 0;
  int checks_done = 0;
  int tk = 0;
  cswu_row_t rows[5] = '{'{8'hc0, 3'h6}, '{8'he0, 3'h7},
    '{8'h60, 3'h3}, '{8'ha0, 3'h5}, '{8'h80, 3'h4}};

  cswu_top dut (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i),
    .slow_tick_i(slow_tick), .fast_tick_i(fast_tick),
    .lower_ctl_wr_i(wr[0]), .upper_ctl_wr_i(wr[1]), .ctl_wdata_i(wd),
    .lower_cmp_wr_i(wr[2]), .upper_cmp_wr_i(wr[3]), .cmp_wdata_i(wd),
    .sysctl_wr_i(wr[4]), .sysctl_wdata_i(wd),
    .irq_enable_high_i(irq_en), .irq_ack_i(wr[5]), .count_o(cnt),
    .upper_timer_run_o(run), .lower_output_flop_o(lflop),
    .upper_output_flop_o(uflop), .system_control_two_o(sys2),
    .fast_osc_en_o(fosc), .slow_osc_en_o(sosc),
    .sysclk_sel_slow_o(sel), .upper_timer_match_pending_o(pend),
    .upper_timer_match_irq_o(irq));
  cswu_osc_model osc (.mclk_i(mclk_i), .srst_i(srst_i),
    .fast_en_i(fosc), .slow_en_i(sosc),
    .slow_tick_o(slow_tick), .fast_tick_o(fast_tick));

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // Counts the source ticks the counter should have taken.
  always @(posedge mclk_i) begin
    if (ce_i && run && (src_slow ? slow_tick : fast_tick)) tk <= tk + 1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr1(input int i, input logic [7:0] d);
    @(posedge mclk_i);
    wr[i] <= 1'b1;
    wd <= d;
    @(posedge mclk_i);
    wr[i] <= 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic sys(input logic [7:0] d, input logic [2:0] e);
    wr1(4, d);
    chk({fosc, sosc, sel}, e);
    chk(sys2[7:5], e);
  endtask
  task automatic to_match(input int n);
    int w = 0;
    while (pend !== 1'b1 && w < 9000) begin
      @(negedge mclk_i);
      w++;
    end
    chk(pend, 16'h0001);
    chk(tk[15:0], n[15:0]);
    chk(cnt, 16'h0000);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(negedge mclk_i);
    chk(sys2, SYSCTL_RST);
    chk(cnt, 16'h0000);
    chk({pend, irq, run, lflop, uflop}, 16'h0000);
    $display("test reset done");
    foreach (rows[i]) sys(rows[i].d, rows[i].e);
    $display("test control two done");
    sys(8'hc0, 3'h6);
    wr1(0, 8'h43);
    wr1(1, 8'h05);
    chk({lflop, uflop, run}, 16'h0000);
    wr1(2, 8'h80);
    wr1(3, 8'h01);
    @(posedge mclk_i);
    irq_en <= 1'b1;
    repeat (20) @(negedge mclk_i);
    chk(cnt, 16'h0000);
    tk = 0;
    wr1(1, 8'h0d);
    to_match(256);
    chk({pend, irq}, 16'h0003);
    wr1(1, 8'h05);
    repeat (20) @(negedge mclk_i);
    chk(cnt, tk[15:0] - 16'd256);
    chk(pend, 16'h0001);
    wr1(5, 8'h00);
    chk({pend, irq}, 16'h0000);
    sys(8'he0, 3'h7);
    sys(8'h60, 3'h3);
    $display("test slow switch done");
    sys(8'he0, 3'h7);
    src_slow = 1'b0;
    wr1(0, 8'h63);
    chk(cnt, 16'h0000);
    wr1(1, 8'h05);
    wr1(2, 8'h00);
    wr1(3, 8'h02);
    @(posedge mclk_i);
    irq_en <= 1'b0;
    tk = 0;
    wr1(1, 8'h0d);
    while (tk < 100) @(negedge mclk_i);
    wr1(1, 8'h05);
    repeat (10) @(negedge mclk_i);
    chk(cnt, tk[15:0]);
    wr1(1, 8'h0d);
    to_match(512);
    chk({pend, irq}, 16'h0002);
    wr1(1, 8'h05);
    @(posedge mclk_i);
    irq_en <= 1'b1;
    repeat (2) @(negedge mclk_i);
    chk(irq, 16'h0001);
    wr1(5, 8'h00);
    chk({pend, irq}, 16'h0000);
    sys(8'hc0, 3'h6);
    sys(8'h80, 3'h4);
    $display("test fast switch done");
    wr1(0, 8'h83);
    wr1(1, 8'h85);
    chk({lflop, uflop, run}, 16'h0006);
    $display("test output flops done");
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr1(1, 8'h0d);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    @(negedge mclk_i);
    chk(run, 16'h0000);
    @(posedge mclk_i);
    srst_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(negedge mclk_i);
    chk(sys2, SYSCTL_RST);
    chk(cnt, 16'h0000);
    chk({pend, irq, run, lflop, uflop}, 16'h0000);
    $display("test freeze and reset done");
    end_sim();
  end
endmodule
`default_nettype wire
